// [pcs_consts.svh]
// constants for the program counter and return stack block
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W 13
`define PCS_STACK_DEPTH 8
`define PCS_PAGE_OFS_W 11
`define PCS_LATCH_W 5
`define PCS_PAGE_LO 3
`define PCS_PAGE_HI 4
`define PCS_PC_RESET 13'h0000
`define PCS_LATCH_RESET 5'h00
`define PCS_PTR_RESET 3'h0
`endif

// [pcs_pkg.sv]
// types for the program counter and return stack block
`include "pcs_consts.svh"
package pcs_pkg;
   typedef logic [`PCS_PC_W-1:0] pcs_addr_t;
   typedef enum logic [2:0] {
      PCS_OP_HOLD = 3'h0,
      PCS_OP_NEXT = 3'h1,
      PCS_OP_BRANCH = 3'h2,
      PCS_OP_CALL = 3'h3,
      PCS_OP_RETURN = 3'h4,
      PCS_OP_INTR = 3'h5,
      PCS_OP_LOW_WR = 3'h6
   } pcs_op_t;
   typedef enum logic [1:0] {
      PCS_RET_PLAIN = 2'h0,
      PCS_RET_LITERAL = 2'h1,
      PCS_RET_INTR = 2'h2
   } pcs_ret_t;
endpackage

// [pcs_stack_if.sv]
// push and pop signals between the sequencer and the return stack
`timescale 1ns/1ps
`default_nettype none
interface pcs_stack_if;
   import pcs_pkg::*;
   logic push;
   logic pop;
   pcs_addr_t push_addr;
   pcs_addr_t top_addr;
   modport seq (output push, output pop, output push_addr, input top_addr);
   modport stk (input push, input pop, input push_addr, output top_addr);
endinterface
`default_nettype wire

// [pcs_return_stack.sv]
// circular return stack held in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_return_stack #(
   parameter int DEPTH = `PCS_STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   pcs_stack_if.stk stk
);
   import pcs_pkg::*;
   localparam int PW = $clog2(DEPTH);
   pcs_addr_t mem_r [DEPTH];
   // pointer is never visible outside; wraps silently, no overflow flag
   logic [PW-1:0] ptr_r;
   wire logic [PW-1:0] ptr_dec;
   assign ptr_dec = ptr_r - PW'(1);
   assign stk.top_addr = mem_r[ptr_dec];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_r <= '0;
      end else if (ce) begin
         if (stk.push) begin
            mem_r[ptr_r] <= stk.push_addr;
            ptr_r <= ptr_r + PW'(1);
         end else if (stk.pop) begin
            ptr_r <= ptr_dec;
         end
      end
   end
endmodule
`default_nettype wire

// [pcs_program_counter.sv]
// program counter, upper latch and page branch forming with return stack
// Overview of operation
// - program counter is 13 bits and addresses the next instruction fetched
// - low byte of the counter is readable and writable by software
// - software writes the upper counter bits only through the upper latch
// - return stack is eight entries of 13 bits, apart from memories
// - stack pointer is internal, never readable or writable
// - push counter on call instruction or interrupt branch
// - pop into counter on return, return with literal, return from interrupt
// - push and pop leave the upper latch unchanged
// - stack is circular, ninth push overwrites first, no overflow flag
// - address space is a continuous 8K words
// - call and jump give eleven address bits, a 2K page
// - top two target bits come from latch bits 4 and 3
// - full 13-bit counter saved, so returns need no page changes
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_program_counter #(
   parameter int DEPTH = `PCS_STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire pcs_pkg::pcs_op_t op,
   input wire pcs_pkg::pcs_ret_t ret_kind,
   input wire logic [`PCS_PAGE_OFS_W-1:0] branch_ofs,
   input wire logic [7:0] low_wr_data,
   input wire logic latch_wr,
   input wire logic [7:0] latch_wr_data,
   output logic [`PCS_PC_W-1:0] fetch_addr,
   output logic [7:0] pc_low_byte,
   output logic [7:0] pc_upper_latch,
   output logic [`PCS_PC_W-1:0] pushed_addr,
   output logic returned,
   output logic returned_from_intr
);
   import pcs_pkg::*;
   pcs_stack_if sif ();

   pcs_return_stack #(.DEPTH(DEPTH)) u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .stk(sif)
   );

   pcs_addr_t pc_r;
   pcs_addr_t pc_nxt;
   logic [`PCS_LATCH_W-1:0] latch_r;
   logic [`PCS_LATCH_W-1:0] latch_nxt;
   pcs_addr_t pushed_r;
   logic returned_r;
   logic ret_intr_r;

   // page target: latch bits 4:3 on top of the 11 offset bits
   wire pcs_addr_t page_target = {latch_r[`PCS_PAGE_HI:`PCS_PAGE_LO], branch_ofs};
   // low byte write also loads the upper bits from the latch
   wire pcs_addr_t low_target = {latch_r, low_wr_data};
   wire pcs_addr_t seq_next = pc_r + `PCS_PC_W'(1);
   wire logic is_push = (op == PCS_OP_CALL) || (op == PCS_OP_INTR);
   wire logic is_pop = (op == PCS_OP_RETURN);

   // return address is the already advanced counter, all 13 bits
   assign sif.push = is_push;
   assign sif.push_addr = pc_r;
   assign sif.pop = is_pop;

   always_comb begin
      case (op)
         PCS_OP_NEXT: pc_nxt = seq_next;
         PCS_OP_BRANCH: pc_nxt = page_target;
         PCS_OP_CALL: pc_nxt = page_target;
         PCS_OP_INTR: pc_nxt = `PCS_PC_RESET + `PCS_PC_W'(4);
         PCS_OP_RETURN: pc_nxt = sif.top_addr;
         PCS_OP_LOW_WR: pc_nxt = low_target;
         default: pc_nxt = pc_r;
      endcase
   end

   // stack operations never touch the latch; only software writes it
   assign latch_nxt = latch_wr ? latch_wr_data[`PCS_LATCH_W-1:0] : latch_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_r <= `PCS_PC_RESET;
         latch_r <= `PCS_LATCH_RESET;
         pushed_r <= `PCS_PC_RESET;
         returned_r <= 1'b0;
         ret_intr_r <= 1'b0;
      end else if (ce) begin
         pc_r <= pc_nxt;
         latch_r <= latch_nxt;
         pushed_r <= is_push ? pc_r : pushed_r;
         returned_r <= is_pop;
         ret_intr_r <= is_pop && (ret_kind == PCS_RET_INTR);
      end
   end

   assign fetch_addr = pc_r;
   assign pc_low_byte = pc_r[7:0];
   assign pc_upper_latch = {3'h0, latch_r};
   assign pushed_addr = pushed_r;
   assign returned = returned_r;
   assign returned_from_intr = ret_intr_r;
endmodule
`default_nettype wire

// [pcs_asserts.sv]
// port checks for the program counter block
`timescale 1ns/1ps
`default_nettype none
module pcs_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire pcs_pkg::pcs_op_t op,
   input wire logic [10:0] branch_ofs,
   input wire logic [7:0] low_wr_data,
   input wire logic latch_wr,
   input wire logic [12:0] fetch_addr,
   input wire logic [7:0] pc_upper_latch,
   input wire logic [12:0] pushed_addr,
   input wire logic returned
);
   import pcs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence call_ret_s;
      ce && op == PCS_OP_CALL ##1 ce && op == PCS_OP_RETURN;
   endsequence
   pc_step_a: assert property (ce && op == PCS_OP_NEXT |=> fetch_addr == $past(fetch_addr) + 13'h1)
      else $error("no step");
   page_jump_a: assert property (ce && op == PCS_OP_BRANCH |=>
      fetch_addr == {$past(pc_upper_latch[4:3]), $past(branch_ofs)}) else $error("bad jump");
   call_push_a: assert property (ce && op == PCS_OP_CALL |=> pushed_addr == $past(fetch_addr))
      else $error("bad push");
   intr_vector_a: assert property (ce && op == PCS_OP_INTR |=> fetch_addr == 13'h0004)
      else $error("bad vector");
   low_write_a: assert property (ce && op == PCS_OP_LOW_WR |=>
      fetch_addr == {$past(pc_upper_latch[4:0]), $past(low_wr_data)}) else $error("bad write");
   latch_hold_a: assert property (!latch_wr |=> $stable(pc_upper_latch)) else $error("latch moved");
   return_pulse_a: assert property (ce |=> returned == ($past(op) == PCS_OP_RETURN))
      else $error("bad pulse");
   round_trip_a: assert property (call_ret_s |=> fetch_addr == $past(fetch_addr, 2))
      else $error("bad return");
endmodule
bind pcs_program_counter pcs_asserts CHK (.*);
`default_nettype wire

// [test_program_counter_stack.sv]
// random and corner tests of the program counter
`timescale 1ns/1ps
`default_nettype none
module test_program_counter_stack;
   import pcs_pkg::*;
   logic clk = 0, rst_n = 0, ce = 1, latch_wr = 0, returned, returned_from_intr, e_ret = 0, e_ri = 0;
   pcs_op_t op = PCS_OP_HOLD;
   pcs_ret_t ret_kind = PCS_RET_PLAIN;
   logic [10:0] branch_ofs = '0;
   logic [7:0] low_wr_data = '0, latch_wr_data = '0, pc_low_byte, pc_upper_latch;
   logic [12:0] fetch_addr, pushed_addr, e_pc = '0, e_push = '0, stk [8];
   logic [4:0] e_lat = '0;
   logic [2:0] sp = '0;
   int errors = 0, checks = 0;
   always #2 clk = ~clk;
   pcs_program_counter DUT (.*);
   task chk(string n, logic [12:0] seen, logic [12:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task results;
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function logic [12:0] nxt(pcs_op_t o);
      case (o)
         PCS_OP_NEXT: return e_pc + 13'h1;
         PCS_OP_BRANCH, PCS_OP_CALL: return {e_lat[4:3], branch_ofs};
         PCS_OP_RETURN: return stk[sp - 3'h1];
         PCS_OP_INTR: return 13'h0004;
         PCS_OP_LOW_WR: return {e_lat, low_wr_data};
         default: return e_pc;
      endcase
   endfunction
   task step(pcs_op_t o, logic c, logic lw, logic [7:0] d);
      op = o;
      ce = c;
      latch_wr = lw;
      low_wr_data = d;
      latch_wr_data = ~d;
      branch_ofs = 11'($urandom);
      ret_kind = pcs_ret_t'($urandom_range(2));
      @(posedge clk);
      if (c) begin
         e_ret = o == PCS_OP_RETURN;
         e_ri = e_ret && ret_kind == PCS_RET_INTR;
         if (o == PCS_OP_CALL || o == PCS_OP_INTR) begin
            stk[sp] = e_pc;
            e_push = e_pc;
         end
         e_pc = nxt(o);
         if (o == PCS_OP_RETURN) sp--;
         if (o == PCS_OP_CALL || o == PCS_OP_INTR) sp++;
         if (lw) e_lat = ~d[4:0];
      end
      #1;
      chk("fetch_addr", fetch_addr, e_pc);
      chk("pc_low_byte", pc_low_byte, e_pc[7:0]);
      chk("pc_upper_latch", pc_upper_latch, {3'h0, e_lat});
      chk("returned", {returned, returned_from_intr}, {e_ret, e_ri});
      chk("pushed_addr", pushed_addr, e_push);
   endtask
   initial begin
      void'($urandom(32'h5802));
      stk = '{default: 13'h0000};
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      step(PCS_OP_HOLD, 1, 1, 8'hE0);
      step(PCS_OP_LOW_WR, 1, 0, 8'hFF);
      step(PCS_OP_NEXT, 1, 0, 8'h00);
      repeat (9) step(PCS_OP_CALL, 1, 1'($urandom), 8'($urandom));
      repeat (10) step(PCS_OP_RETURN, 1, 1'($urandom), 8'($urandom));
      repeat (400) step(pcs_op_t'($urandom_range(6)), $urandom_range(7) != 0, 1'($urandom), 8'($urandom));
      results();
   end
   initial begin
      #20000;
      errors++;
      results();
   end
endmodule
`default_nettype wire
